//--- pole_detect_pkg.sv
package pole_detect_pkg;
  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_PHASE_INDUCTANCE = 14'h3908;
  localparam logic [13:0] IDX_PHASE_RESISTANCE = 14'h3909;
  localparam logic [13:0] IDX_CURRENT_RESPONSE_AUTO_TUNE = 14'h3912;
  localparam logic [13:0] IDX_CURRENT_PROPORTIONAL_GAIN = 14'h3913;
  localparam logic [13:0] IDX_CURRENT_INTEGRAL_GAIN = 14'h3914;
  localparam logic [13:0] IDX_POLE_DETECT_METHOD = 14'h3920;
  localparam logic [13:0] IDX_ESTIMATE_FORCE_TIME = 14'h3922;
  localparam logic [13:0] IDX_ESTIMATE_FORCE_LEVEL = 14'h3923;
  localparam logic [13:0] IDX_ZERO_MOVE_PULSE_WIDTH = 14'h3924;
  localparam logic [13:0] IDX_STOP_MOVE_THRESHOLD = 14'h3925;
  localparam logic [13:0] IDX_STOP_JUDGE_TIME = 14'h3926;
  localparam logic [13:0] IDX_STOP_TIME_LIMIT = 14'h3927;
  localparam logic [13:0] IDX_ESTIMATE_FORCE_FILTER = 14'h3328;
  localparam logic [13:0] IDX_DETECT_STATUS = 14'h3A00;
  localparam logic [13:0] IDX_IRQ_STATUS = 14'h3A01;
  localparam logic [13:0] IDX_IRQ_ENABLE = 14'h3A02;
  localparam logic [13:0] IDX_IRQ_CLEAR = 14'h3A03;
  localparam logic [13:0] IDX_POLE_ANGLE = 14'h3A04;

  // method selector codes
  localparam logic [15:0] METHOD_ESTIMATE = 16'h0002;
  localparam logic [15:0] METHOD_RESTORE = 16'h0003;

  // status and interrupt bit positions
  localparam int BIT_DONE = 0;
  localparam int BIT_ERR_STOP = 1;
  localparam int BIT_ERR_OVERLOAD = 2;
  localparam int BIT_BUSY = 3;
  localparam int BIT_READY = 4;
  localparam int IRQ_W = 3;

  // reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_RESPONSE = 16'h0064;
  localparam logic [15:0] RST_FORCE_TIME = 16'h0064;
  localparam logic [15:0] RST_FORCE_LEVEL = 16'h0064;

  // gain scaling: gain = (winding value * response) >> shift
  localparam int GAIN_SHIFT = 8;

  // timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int MS_PS = 1000000000;
  localparam int MS_CYCLES = MS_PS / CLK_PERIOD_PS;
  localparam int WINDOW_MS = 2;
  localparam int FILTER_STEP_PS = 10000000;
  localparam int FILTER_STEP_CYCLES = FILTER_STEP_PS / CLK_PERIOD_PS;

  // angle step between trials (quarter turn)
  localparam logic [15:0] ANGLE_STEP = 16'h4000;

  typedef enum logic [1:0] {AXI_OKAY = 2'b00, AXI_SLVERR = 2'b10} axi_resp_t;

  typedef struct packed {
    logic [15:0] force_time;
    logic [15:0] force_level;
    logic [15:0] zero_width;
    logic [15:0] stop_thr;
    logic [15:0] stop_time;
    logic [15:0] stop_limit;
  } est_cfg_t;
endpackage

//--- pole_detect.sv
`timescale 1ns/1ps
// Function
// - estimate pole at first servo-on after power-up
// - pole data kept until power reset
// - method value 2 selects estimation
// - each force applied for set milliseconds
// - force magnitude from percentage setting
// - travel below pulse width means no move
// - stop: window counts within threshold long enough
// - no stop before limit raises error 61.1
// - force filter in 0.01 ms, zero disables
// - gains computed from inductance, resistance, response
// - long heavy forcing reports overload 16.0
// - settings except the force filter captured when estimation starts
// - method value 3 restores stored pole data
// - several force trials judge direction
module pole_detect #(
  parameter int MS_COUNT = pole_detect_pkg::MS_CYCLES,
  parameter int N_TRIALS = 4,
  parameter logic [31:0] OVERLOAD_LIMIT = 32'h0001_86A0,
  parameter logic [15:0] OVERLOAD_COOL = 16'h0032
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // drive pins
  input wire logic servo_on,
  input wire logic enc_a,
  input wire logic enc_b,
  // motor side
  output logic [15:0] force_cmd,
  output logic [15:0] force_angle,
  output logic [15:0] current_kp,
  output logic [15:0] current_ki,
  output logic servo_ready,
  output logic irq
);
  typedef enum logic [2:0] {ST_IDLE, ST_FORCE, ST_SETTLE, ST_DONE, ST_FAIL} st_t;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and encoder
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;
  logic signed [31:0] enc_pos_q;
  logic on_s;
  logic a_s;
  logic b_s;
  logic on_rise;
  logic cnt_up;
  logic cnt_dn;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      prev_q <= 3'h0;
    end else begin
      sync1_q <= {servo_on, enc_b, enc_a};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign on_s = sync2_q[2];
  assign b_s = sync2_q[1];
  assign a_s = sync2_q[0];
  assign on_rise = on_s & ~prev_q[2];
  // x4 quadrature: a leading b counts up
  assign cnt_up = (a_s ^ prev_q[0]) ? (a_s ^ b_s) : ((b_s ^ prev_q[1]) & ~(a_s ^ b_s));
  assign cnt_dn = (a_s ^ prev_q[0]) ? ~(a_s ^ b_s) : ((b_s ^ prev_q[1]) & (a_s ^ b_s));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enc_pos_q <= 32'sh0000_0000;
    end else if (cnt_up) begin
      enc_pos_q <= enc_pos_q + 32'sh0000_0001;
    end else if (cnt_dn) begin
      enc_pos_q <= enc_pos_q - 32'sh0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register file and axi4-lite slave
  logic [15:0] inductance_q;
  logic [15:0] resistance_q;
  logic [15:0] response_q;
  logic [15:0] kp_q;
  logic [15:0] ki_q;
  logic [15:0] method_q;
  logic [15:0] filter_tc_q;
  logic [15:0] pole_angle_q;
  localparam int IRQ_W_L = pole_detect_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] irq_en_q;
  logic [IRQ_W_L-1:0] irq_st_q;
  pole_detect_pkg::est_cfg_t cfg_reg_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [13:0] aw_idx_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_go;
  logic [15:0] wv;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic wr_ok;
  logic [31:0] kp_calc;
  logic [31:0] ki_calc;
  logic irq_clr_wr;
  logic [IRQ_W_L-1:0] ev;
  logic tune_q;
  logic done_q;

  assign wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  assign wv = {w_strb_q[1] ? w_data_q[15:8] : 8'h00, w_strb_q[0] ? w_data_q[7:0] : 8'h00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_idx_q <= 14'h0000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pole_detect_pkg::AXI_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[15:2];
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? pole_detect_pkg::AXI_OKAY : pole_detect_pkg::AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;

  always_comb begin
    case (aw_idx_q)
      pole_detect_pkg::IDX_PHASE_INDUCTANCE, pole_detect_pkg::IDX_PHASE_RESISTANCE,
      pole_detect_pkg::IDX_CURRENT_RESPONSE_AUTO_TUNE,
      pole_detect_pkg::IDX_CURRENT_PROPORTIONAL_GAIN,
      pole_detect_pkg::IDX_CURRENT_INTEGRAL_GAIN, pole_detect_pkg::IDX_POLE_DETECT_METHOD,
      pole_detect_pkg::IDX_ESTIMATE_FORCE_TIME, pole_detect_pkg::IDX_ESTIMATE_FORCE_LEVEL,
      pole_detect_pkg::IDX_ZERO_MOVE_PULSE_WIDTH, pole_detect_pkg::IDX_STOP_MOVE_THRESHOLD,
      pole_detect_pkg::IDX_STOP_JUDGE_TIME, pole_detect_pkg::IDX_STOP_TIME_LIMIT,
      pole_detect_pkg::IDX_ESTIMATE_FORCE_FILTER, pole_detect_pkg::IDX_IRQ_ENABLE,
      pole_detect_pkg::IDX_IRQ_CLEAR, pole_detect_pkg::IDX_POLE_ANGLE: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // written gains hold until the next tune write
  assign kp_calc = (32'(inductance_q) * 32'(response_q)) >> pole_detect_pkg::GAIN_SHIFT;
  assign ki_calc = (32'(resistance_q) * 32'(response_q)) >> pole_detect_pkg::GAIN_SHIFT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inductance_q <= pole_detect_pkg::RST_ZERO;
      resistance_q <= pole_detect_pkg::RST_ZERO;
      response_q <= pole_detect_pkg::RST_RESPONSE;
      kp_q <= pole_detect_pkg::RST_ZERO;
      ki_q <= pole_detect_pkg::RST_ZERO;
      method_q <= pole_detect_pkg::RST_ZERO;
      filter_tc_q <= pole_detect_pkg::RST_ZERO;
      irq_en_q <= '0;
      cfg_reg_q <= '{pole_detect_pkg::RST_FORCE_TIME, pole_detect_pkg::RST_FORCE_LEVEL,
                     16'h0000, 16'h0000, 16'h0000, 16'h0000};
    end else if (wr_go) begin
      case (aw_idx_q)
        pole_detect_pkg::IDX_PHASE_INDUCTANCE: inductance_q <= wv;
        pole_detect_pkg::IDX_PHASE_RESISTANCE: resistance_q <= wv;
        pole_detect_pkg::IDX_CURRENT_RESPONSE_AUTO_TUNE: begin
          response_q <= wv;
        end
        pole_detect_pkg::IDX_CURRENT_PROPORTIONAL_GAIN: kp_q <= wv;
        pole_detect_pkg::IDX_CURRENT_INTEGRAL_GAIN: ki_q <= wv;
        pole_detect_pkg::IDX_POLE_DETECT_METHOD: method_q <= wv;
        pole_detect_pkg::IDX_ESTIMATE_FORCE_TIME: cfg_reg_q.force_time <= wv;
        pole_detect_pkg::IDX_ESTIMATE_FORCE_LEVEL: cfg_reg_q.force_level <= wv;
        pole_detect_pkg::IDX_ZERO_MOVE_PULSE_WIDTH: cfg_reg_q.zero_width <= wv;
        pole_detect_pkg::IDX_STOP_MOVE_THRESHOLD: cfg_reg_q.stop_thr <= wv;
        pole_detect_pkg::IDX_STOP_JUDGE_TIME: cfg_reg_q.stop_time <= wv;
        pole_detect_pkg::IDX_STOP_TIME_LIMIT: cfg_reg_q.stop_limit <= wv;
        pole_detect_pkg::IDX_ESTIMATE_FORCE_FILTER: filter_tc_q <= wv;
        pole_detect_pkg::IDX_IRQ_ENABLE: irq_en_q <= wv[IRQ_W_L-1:0];
        default: begin
        end
      endcase
    end else if (tune_q) begin
      kp_q <= kp_calc[15:0];
      ki_q <= ki_calc[15:0];
    end
  end

  // auto tune runs one cycle after a write to the response register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tune_q <= 1'b0;
    end else begin
      tune_q <= wr_go & (aw_idx_q == pole_detect_pkg::IDX_CURRENT_RESPONSE_AUTO_TUNE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read channel
  st_t st_q;
  logic pole_valid_q;
  logic err_stop_q;
  logic err_ol_q;

  always_comb begin
    rd_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr[15:2])
      pole_detect_pkg::IDX_PHASE_INDUCTANCE: rd_mux[15:0] = inductance_q;
      pole_detect_pkg::IDX_PHASE_RESISTANCE: rd_mux[15:0] = resistance_q;
      pole_detect_pkg::IDX_CURRENT_RESPONSE_AUTO_TUNE: rd_mux[15:0] = response_q;
      pole_detect_pkg::IDX_CURRENT_PROPORTIONAL_GAIN: rd_mux[15:0] = kp_q;
      pole_detect_pkg::IDX_CURRENT_INTEGRAL_GAIN: rd_mux[15:0] = ki_q;
      pole_detect_pkg::IDX_POLE_DETECT_METHOD: rd_mux[15:0] = method_q;
      pole_detect_pkg::IDX_ESTIMATE_FORCE_TIME: rd_mux[15:0] = cfg_reg_q.force_time;
      pole_detect_pkg::IDX_ESTIMATE_FORCE_LEVEL: rd_mux[15:0] = cfg_reg_q.force_level;
      pole_detect_pkg::IDX_ZERO_MOVE_PULSE_WIDTH: rd_mux[15:0] = cfg_reg_q.zero_width;
      pole_detect_pkg::IDX_STOP_MOVE_THRESHOLD: rd_mux[15:0] = cfg_reg_q.stop_thr;
      pole_detect_pkg::IDX_STOP_JUDGE_TIME: rd_mux[15:0] = cfg_reg_q.stop_time;
      pole_detect_pkg::IDX_STOP_TIME_LIMIT: rd_mux[15:0] = cfg_reg_q.stop_limit;
      pole_detect_pkg::IDX_ESTIMATE_FORCE_FILTER: rd_mux[15:0] = filter_tc_q;
      pole_detect_pkg::IDX_DETECT_STATUS: begin
        rd_mux[pole_detect_pkg::BIT_DONE] = pole_valid_q;
        rd_mux[pole_detect_pkg::BIT_ERR_STOP] = err_stop_q;
        rd_mux[pole_detect_pkg::BIT_ERR_OVERLOAD] = err_ol_q;
        rd_mux[pole_detect_pkg::BIT_BUSY] = (st_q == ST_FORCE) | (st_q == ST_SETTLE);
        rd_mux[pole_detect_pkg::BIT_READY] = servo_ready;
      end
      pole_detect_pkg::IDX_IRQ_STATUS: rd_mux[IRQ_W_L-1:0] = irq_st_q;
      pole_detect_pkg::IDX_IRQ_ENABLE: rd_mux[IRQ_W_L-1:0] = irq_en_q;
      pole_detect_pkg::IDX_IRQ_CLEAR: rd_mux = 32'h0000_0000;
      pole_detect_pkg::IDX_POLE_ANGLE: rd_mux[15:0] = pole_angle_q;
      default: rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pole_detect_pkg::AXI_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? pole_detect_pkg::AXI_OKAY : pole_detect_pkg::AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // millisecond and window timing
  logic [31:0] ms_cnt_q;
  logic ms_tick;
  logic [1:0] win_cnt_q;
  logic win_tick;
  logic signed [31:0] win_start_q;
  logic signed [31:0] win_move;
  logic [31:0] win_abs;

  assign ms_tick = (ms_cnt_q == 32'(MS_COUNT - 1));
  assign win_tick = ms_tick & (win_cnt_q == 2'(pole_detect_pkg::WINDOW_MS - 1));
  assign win_move = enc_pos_q - win_start_q;
  assign win_abs = win_move[31] ? 32'(-win_move) : 32'(win_move);

  always_ff @(posedge aclk) begin
    if (!aresetn || st_q == ST_IDLE) begin
      ms_cnt_q <= 32'h0000_0000;
      win_cnt_q <= 2'h0;
      win_start_q <= 32'sh0000_0000;
    end else begin
      ms_cnt_q <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
      if (ms_tick) begin
        win_cnt_q <= win_tick ? 2'h0 : win_cnt_q + 2'h1;
      end
      if (win_tick) begin
        win_start_q <= enc_pos_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // estimation sequencer
  pole_detect_pkg::est_cfg_t cfg_q;
  logic [15:0] phase_ms_q;
  logic [15:0] still_ms_q;
  logic [7:0] trial_q;
  logic [15:0] test_angle_q;
  logic signed [31:0] trial_start_q;
  logic signed [31:0] best_move_q;
  logic signed [31:0] trial_move;
  logic [31:0] trial_abs;
  logic [15:0] target_q;
  logic est_start;
  logic restore_start;
  logic ol_trip;

  assign est_start = on_rise & ~pole_valid_q &
    (method_q == pole_detect_pkg::METHOD_ESTIMATE);
  assign restore_start = on_rise & ~pole_valid_q &
    (method_q == pole_detect_pkg::METHOD_RESTORE);
  assign trial_move = enc_pos_q - trial_start_q;
  assign trial_abs = trial_move[31] ? 32'(-trial_move) : 32'(trial_move);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
      cfg_q <= '0;
      phase_ms_q <= 16'h0000;
      still_ms_q <= 16'h0000;
      trial_q <= 8'h00;
      test_angle_q <= 16'h0000;
      trial_start_q <= 32'sh0000_0000;
      best_move_q <= 32'sh0000_0000;
      pole_angle_q <= 16'h0000;
      pole_valid_q <= 1'b0;
      err_stop_q <= 1'b0;
      err_ol_q <= 1'b0;
      target_q <= 16'h0000;
    end else begin
      if (wr_go && aw_idx_q == pole_detect_pkg::IDX_POLE_ANGLE) begin
        pole_angle_q <= wv;
      end
      case (st_q)
        ST_IDLE: begin
          if (est_start) begin
            cfg_q <= cfg_reg_q;
            st_q <= ST_FORCE;
            trial_q <= 8'h00;
            test_angle_q <= 16'h0000;
            trial_start_q <= enc_pos_q;
            best_move_q <= 32'sh0000_0000;
            phase_ms_q <= 16'h0000;
            target_q <= cfg_reg_q.force_level;
          end else if (restore_start) begin
            pole_valid_q <= 1'b1;
            st_q <= ST_DONE;
          end
        end
        ST_FORCE: begin
          if (ms_tick) begin
            phase_ms_q <= phase_ms_q + 16'h0001;
          end
          if (ms_tick && phase_ms_q + 16'h0001 >= cfg_q.force_time) begin
            target_q <= 16'h0000;
            phase_ms_q <= 16'h0000;
            still_ms_q <= 16'h0000;
            st_q <= ST_SETTLE;
            // forward travel of at least the zero width counts
            if (trial_abs >= 32'(cfg_q.zero_width) && trial_move > best_move_q) begin
              best_move_q <= trial_move;
              pole_angle_q <= test_angle_q;
            end
          end
        end
        ST_SETTLE: begin
          if (ms_tick) begin
            phase_ms_q <= phase_ms_q + 16'h0001;
          end
          if (win_tick) begin
            still_ms_q <= (win_abs <= 32'(cfg_q.stop_thr)) ?
                          still_ms_q + 16'(pole_detect_pkg::WINDOW_MS) : 16'h0000;
          end
          if (still_ms_q >= cfg_q.stop_time && still_ms_q != 16'h0000) begin
            if (trial_q == 8'(N_TRIALS - 1)) begin
              pole_valid_q <= 1'b1;
              st_q <= ST_DONE;
            end else begin
              trial_q <= trial_q + 8'h01;
              test_angle_q <= test_angle_q + pole_detect_pkg::ANGLE_STEP;
              trial_start_q <= enc_pos_q;
              phase_ms_q <= 16'h0000;
              target_q <= cfg_q.force_level;
              st_q <= ST_FORCE;
            end
          end else if (ms_tick && phase_ms_q + 16'h0001 >= cfg_q.stop_limit) begin
            err_stop_q <= 1'b1;
            st_q <= ST_FAIL;
          end
        end
        ST_DONE: begin
        end
        ST_FAIL: begin
          target_q <= 16'h0000;
        end
        default: st_q <= ST_IDLE;
      endcase
      if (ol_trip && (st_q == ST_FORCE || st_q == ST_SETTLE)) begin
        err_ol_q <= 1'b1;
        target_q <= 16'h0000;
        st_q <= ST_FAIL;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // force filter and overload integrator
  logic [15:0] filt_q;
  logic [10:0] fstep_cnt_q;
  logic fstep;
  logic signed [31:0] facc_q;
  logic [31:0] ol_acc_q;

  assign fstep = (fstep_cnt_q == 11'(pole_detect_pkg::FILTER_STEP_CYCLES - 1));
  assign ol_trip = (ol_acc_q >= OVERLOAD_LIMIT);

  // first-order lag: slope is (target - out) per tc steps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_q <= 16'h0000;
      fstep_cnt_q <= 11'h000;
      facc_q <= 32'sh0000_0000;
    end else if (filter_tc_q == 16'h0000) begin
      filt_q <= target_q;
      facc_q <= 32'sh0000_0000;
      fstep_cnt_q <= 11'h000;
    end else begin
      fstep_cnt_q <= fstep ? 11'h000 : fstep_cnt_q + 11'h001;
      if (fstep) begin
        facc_q <= facc_q + (32'(target_q) - 32'(filt_q));
      end else if (facc_q >= signed'(32'(filter_tc_q))) begin
        facc_q <= facc_q - 32'(filter_tc_q);
        filt_q <= filt_q + 16'h0001;
      end else if (facc_q <= -signed'(32'(filter_tc_q))) begin
        facc_q <= facc_q + 32'(filter_tc_q);
        filt_q <= filt_q - 16'h0001;
      end
    end
  end

  // heat grows with force each ms and cools while no force is out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ol_acc_q <= 32'h0000_0000;
    end else if (ms_tick) begin
      if (filt_q != 16'h0000) begin
        ol_acc_q <= ol_acc_q + 32'(filt_q);
      end else begin
        ol_acc_q <= (ol_acc_q > 32'(OVERLOAD_COOL)) ? ol_acc_q - 32'(OVERLOAD_COOL) : 32'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts and outputs
  assign ev = {ol_trip & ~err_ol_q & (st_q == ST_FORCE || st_q == ST_SETTLE),
               (st_q == ST_SETTLE) & ms_tick & (phase_ms_q + 16'h0001 >= cfg_q.stop_limit),
               pole_valid_q & ~done_q};
  assign irq_clr_wr = wr_go & (aw_idx_q == pole_detect_pkg::IDX_IRQ_CLEAR);

  // a fresh event wins over a clear written in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_q <= '0;
      done_q <= 1'b0;
    end else begin
      irq_st_q <= (irq_st_q & ~(irq_clr_wr ? wv[IRQ_W_L-1:0] : '0)) | ev;
      done_q <= pole_valid_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
      servo_ready <= 1'b0;
      force_cmd <= 16'h0000;
      force_angle <= 16'h0000;
      current_kp <= 16'h0000;
      current_ki <= 16'h0000;
    end else begin
      irq <= |(irq_st_q & irq_en_q);
      servo_ready <= on_s & pole_valid_q & ~err_stop_q & ~err_ol_q;
      force_cmd <= filt_q;
      force_angle <= test_angle_q;
      current_kp <= kp_q;
      current_ki <= ki_q;
    end
  end
endmodule // pole_detect

//--- motor_model.sv
`timescale 1ns/1ps
module motor_model (
  // drive side
  input wire logic aclk,
  input wire logic [15:0] force_cmd,
  input wire logic [15:0] force_angle,
  input wire logic drift,
  // encoder
  output logic enc_a,
  output logic enc_b
);
  logic [3:0] pos_q = 4'h0;
  // pole at the quarter-turn trial; drift never lets it stop
  always_ff @(posedge aclk) begin
    if (drift || (force_cmd != 16'h0000 && force_angle == 16'h4000)) begin
      pos_q <= pos_q + 4'h1;
    end
  end
  assign enc_a = pos_q[3] ^ pos_q[2];
  assign enc_b = pos_q[3];
endmodule // motor_model

//--- pole_detect_chk.sv
`timescale 1ns/1ps
module pole_detect_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // drive pins
  input wire logic servo_on,
  input wire logic servo_ready,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !servo_ready && !irq)
    else $error("outputs active after reset");
  a_ready_late: assert property ($rose(servo_ready) |-> $past(servo_on, 3))
    else $error("ready without servo on");
  a_write_answer: assert property (s_write_taken |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answered twice");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answered twice");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
endmodule // pole_detect_chk
bind pole_detect pole_detect_chk i_chk (.*);

//--- tb_pole_detect.sv
`timescale 1ns/1ps
module tb_pole_detect;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic servo_on, enc_a, enc_b, servo_ready, irq, drift;
  logic [15:0] s_axi_awaddr, s_axi_araddr, force_cmd, force_angle, current_kp, current_ki;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
  int n_fail, n_tests;
  // short ms and overload limit
  pole_detect #(.MS_COUNT(20), .OVERLOAD_LIMIT(32'h0000_01F4)) i_dut (.*);
  motor_model i_motor (.*);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [13:0] idx, input logic [15:0] d);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50 && !s_axi_bvalid; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (k == 50) chk("write timeout", 1, 0);
  endtask
  task automatic rd(input logic [13:0] idx);
    int k;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50 && !s_axi_rvalid; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    if (k == 50) chk("read timeout", 1, 0);
  endtask
  task automatic rdc(input logic [13:0] idx, input logic [15:0] exp);
    rd(idx);
    chk("rdata", rdat, {16'h0000, exp});
  endtask
  task rst;
    aresetn <= 1'b0;
    servo_on <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic run(input logic [15:0] m, input logic [15:0] ft, input logic d);
    int k;
    rst();
    drift <= d;
    wr(pole_detect_pkg::IDX_POLE_DETECT_METHOD, m);
    wr(pole_detect_pkg::IDX_ESTIMATE_FORCE_TIME, ft);
    wr(pole_detect_pkg::IDX_ZERO_MOVE_PULSE_WIDTH, 16'h0002);
    wr(pole_detect_pkg::IDX_STOP_MOVE_THRESHOLD, 16'h0000);
    wr(pole_detect_pkg::IDX_STOP_JUDGE_TIME, 16'h0004);
    wr(pole_detect_pkg::IDX_STOP_TIME_LIMIT, 16'h0014);
    wr(pole_detect_pkg::IDX_ESTIMATE_FORCE_FILTER, 16'h0000);
    wr(pole_detect_pkg::IDX_IRQ_ENABLE, 16'h0007);
    servo_on <= 1'b1;
    // captured at start, so this must not apply
    wr(pole_detect_pkg::IDX_ESTIMATE_FORCE_TIME, 16'h00C8);
    for (k = 0; k < 3000 && !(irq || servo_ready); k++) @(posedge aclk);
    if (k == 3000) chk("run timeout", 1, 0);
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, drift} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, servo_on, aresetn, n_fail, n_tests} = '0;
    s_axi_wstrb = 4'hF;
    rst();
    rdc(pole_detect_pkg::IDX_CURRENT_RESPONSE_AUTO_TUNE, pole_detect_pkg::RST_RESPONSE);
    rd(14'h0001);
    chk("unmapped rresp", rrsp, pole_detect_pkg::AXI_SLVERR);
    wr(pole_detect_pkg::IDX_PHASE_INDUCTANCE, 16'h0100);
    wr(pole_detect_pkg::IDX_PHASE_RESISTANCE, 16'h0200);
    wr(pole_detect_pkg::IDX_CURRENT_RESPONSE_AUTO_TUNE, 16'h0080);
    repeat (3) @(posedge aclk);
    chk("current_kp", current_kp, 16'h0080);
    chk("current_ki", current_ki, 16'h0100);
    wr(pole_detect_pkg::IDX_CURRENT_PROPORTIONAL_GAIN, 16'h1234);
    rdc(pole_detect_pkg::IDX_CURRENT_PROPORTIONAL_GAIN, 16'h1234);
    $display("test gains done");
    run(pole_detect_pkg::METHOD_ESTIMATE, 16'h0001, 1'b0);
    chk("servo_ready", servo_ready, 1'b1);
    chk("irq", irq, 1'b1);
    rdc(pole_detect_pkg::IDX_POLE_ANGLE, pole_detect_pkg::ANGLE_STEP);
    chk("force_angle", force_angle, 16'hC000);
    wr(pole_detect_pkg::IDX_IRQ_ENABLE, 16'h0000);
    repeat (2) @(posedge aclk);
    chk("irq masked", irq, 1'b0);
    rdc(pole_detect_pkg::IDX_IRQ_STATUS, 16'h0001);
    wr(pole_detect_pkg::IDX_IRQ_CLEAR, 16'h0001);
    wr(pole_detect_pkg::IDX_IRQ_ENABLE, 16'h0007);
    repeat (2) @(posedge aclk);
    chk("irq cleared", irq, 1'b0);
    rdc(pole_detect_pkg::IDX_IRQ_STATUS, 16'h0000);
    $display("test estimate done");
    run(pole_detect_pkg::METHOD_ESTIMATE, 16'h0001, 1'b1);
    chk("servo_ready", servo_ready, 1'b0);
    rd(pole_detect_pkg::IDX_DETECT_STATUS);
    chk("stop error", rdat[pole_detect_pkg::BIT_ERR_STOP], 1'b1);
    $display("test stop timeout done");
    run(pole_detect_pkg::METHOD_ESTIMATE, 16'h0014, 1'b0);
    rd(pole_detect_pkg::IDX_DETECT_STATUS);
    chk("overload", rdat[pole_detect_pkg::BIT_ERR_OVERLOAD], 1'b1);
    chk("force_cmd", force_cmd, 16'h0000);
    $display("test overload done");
    run(pole_detect_pkg::METHOD_RESTORE, 16'h0001, 1'b0);
    chk("servo_ready", servo_ready, 1'b1);
    $display("test restore done");
    wrap_up();
  end
endmodule // tb_pole_detect
